/* include/pcc_pkg.sv */
/*
 * pcc_pkg: register indices, field positions, reset values and mode codes
 * for the compare unit. Assumes a 32-bit APB bus with byte addressing, so
 * each register index maps to byte address index*4.
 */
package pcc_pkg;
    localparam int          CNT_W          = 16;
    localparam int          ADDR_W         = 8;

    // register indices; byte address is index*4
    localparam logic [5:0]  IDX_TB_CTL     = 6'h00;
    localparam logic [5:0]  IDX_TB_STATUS  = 6'h01;
    localparam logic [5:0]  IDX_PHASE      = 6'h03;
    localparam logic [5:0]  IDX_PERIOD     = 6'h05;
    localparam logic [5:0]  IDX_CMP_CTL    = 6'h07;
    localparam logic [5:0]  IDX_CMP_A_FRAC = 6'h08;
    localparam logic [5:0]  IDX_CMP_A      = 6'h09;
    localparam logic [5:0]  IDX_CMP_B      = 6'h0a;

    // time-base control and status fields
    localparam int          TB_MODE_LSB    = 0;
    localparam int          TB_PHASE_EN    = 2;
    localparam int          TB_SYNC_DIR    = 3;
    localparam int          STATUS_DIR     = 16;

    // counter modes
    localparam logic [1:0]  MODE_UP        = 2'h0;
    localparam logic [1:0]  MODE_DOWN      = 2'h1;
    localparam logic [1:0]  MODE_UPDOWN    = 2'h2;
    localparam logic [1:0]  MODE_FROZEN    = 2'h3;

    // compare control fields: load select at [2ch+1:2ch], disable at 4+2ch
    localparam int          CMP_LOAD_LSB   = 0;
    localparam int          CMP_SHDW_LSB   = 4;
    localparam logic [1:0]  LOAD_ZERO      = 2'h0;
    localparam logic [1:0]  LOAD_PERIOD    = 2'h1;
    localparam logic [1:0]  LOAD_BOTH      = 2'h2;

    // reset values
    localparam logic [1:0]  TB_MODE_RST    = MODE_FROZEN;
    localparam logic [7:0]  CMP_CTL_RST    = 8'h00;
    localparam logic [15:0] PERIOD_RST     = 16'hffff;
    localparam logic [15:0] PHASE_RST      = 16'h0000;
    localparam logic [15:0] CMP_RST        = 16'h0000;
endpackage : pcc_pkg

/* rtl/pcc_compare_unit.sv */
/*
 * pcc_compare_unit: two-channel counter-compare unit with its time-base
 * counter and an APB register slave. Assumes pcc_pkg is compiled first,
 * syncInput comes from another domain, and the action qualifier reads the
 * event outputs on this same clock.
 */
// Chosen here: the APB slave port.
`timescale 1ns/1ps

// Operation
// RULE1: compare counter with both active values continuously
// RULE2: up or down mode: one event per period
// RULE3: up-down: two events, one at ends
// RULE4: events go out to action qualifier
// RULE5: shadow and active share one address
// RULE6: clearing disable bit enables shadow per channel
// RULE7: reset leaves both channels in shadow mode
// RULE8: shadow loads at zero, period or both
// RULE9: only active values drive events
// RULE10: disable bit set: access hits active copy
// RULE11: sync jumps may skip an event
// RULE12: fraction location reserved, no function
// RULE13: events in up, down, up-down modes
// RULE14: sync with phase enable loads phase value
// RULE15: four counter modes, frozen holds value
// RULE16: 16-bit unsigned equality each clock
module pcc_compare_unit (
    input  wire logic        clock,         // time-base clock
    input  wire logic        reset,         // async, active high
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic             pready,        // apb ready
    output logic      [31:0] prdata,        // apb read data
    output logic             pslverr,       // apb error
    input  wire logic        syncInput,     // external sync pulse
    output logic             eventA,        // unfrozen counter equals active a
    output logic             eventB,        // unfrozen counter equals active b
    output logic             counterZero,   // counter equals zero
    output logic             counterPeriod, // counter equals period
    output logic             countUp,       // counter direction
    output logic      [15:0] baseCounter    // time-base counter
);
    logic [1:0]  tbMode;
    logic        phaseLoadEnable;
    logic        postSyncDirection;
    logic [15:0] phaseValue;
    logic [15:0] basePeriod;
    logic [7:0]  compareControl;
    logic [15:0] activeValue [2];
    logic [15:0] shadowValue [2];
    logic [15:0] readCompare [2];
    logic [1:0]  cmpEvent;
    logic        syncMeta;
    logic        syncSeen;
    logic        syncLast;
    logic        syncLoad;

    logic [1:0]  next_tbMode;
    logic        next_phaseLoadEnable;
    logic        next_postSyncDirection;
    logic [15:0] next_phaseValue;
    logic [15:0] next_basePeriod;
    logic [7:0]  next_compareControl;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic [15:0] next_baseCounter;
    logic        next_countUp;
    logic        next_counterZero;
    logic        next_counterPeriod;

    logic [5:0]  regIndex;
    logic        badAddr;
    logic        wrEn;
    logic [15:0] readValue;

    assign eventA   = cmpEvent[0];  // RULE4
    assign eventB   = cmpEvent[1];  // RULE4
    assign regIndex = paddr[7:2];
    assign wrEn     = psel & penable & pready & pwrite & ~badAddr;
    assign syncLoad = syncSeen & ~syncLast & phaseLoadEnable;  // RULE11

    // address decode and read mux
    always_comb begin
        badAddr   = (paddr[1:0] != 2'h0);
        readValue = 16'h0000;
        case (regIndex)
            pcc_pkg::IDX_TB_CTL: begin
                readValue = {12'h000, postSyncDirection, phaseLoadEnable,
                             tbMode};
            end
            pcc_pkg::IDX_TB_STATUS:  readValue = baseCounter;
            pcc_pkg::IDX_PHASE:      readValue = phaseValue;
            pcc_pkg::IDX_PERIOD:     readValue = basePeriod;
            pcc_pkg::IDX_CMP_CTL:    readValue = {8'h00, compareControl};
            pcc_pkg::IDX_CMP_A_FRAC: readValue = 16'h0000;  // RULE12
            pcc_pkg::IDX_CMP_A:      readValue = readCompare[0];  // RULE5
            pcc_pkg::IDX_CMP_B:      readValue = readCompare[1];  // RULE5
            default:                 badAddr = 1'b1;
        endcase
    end

    // apb answer one cycle into the access phase
    always_comb begin
        next_pready  = psel & penable & ~pready;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (next_pready) begin
            next_pslverr = badAddr;
            next_prdata  = 32'h0000_0000;
            if (!pwrite && !badAddr) begin
                next_prdata = {15'h0000, countUp & (regIndex ==
                    pcc_pkg::IDX_TB_STATUS), readValue};
            end
        end
    end

    // software-visible control state
    always_comb begin
        next_tbMode            = tbMode;
        next_phaseLoadEnable   = phaseLoadEnable;
        next_postSyncDirection = postSyncDirection;
        next_phaseValue        = phaseValue;
        next_basePeriod        = basePeriod;
        next_compareControl    = compareControl;
        if (wrEn) begin
            case (regIndex)
                pcc_pkg::IDX_TB_CTL: begin
                    next_tbMode = pwdata[pcc_pkg::TB_MODE_LSB +: 2];
                    next_phaseLoadEnable   = pwdata[pcc_pkg::TB_PHASE_EN];
                    next_postSyncDirection = pwdata[pcc_pkg::TB_SYNC_DIR];
                end
                pcc_pkg::IDX_PHASE:   next_phaseValue = pwdata[15:0];
                pcc_pkg::IDX_PERIOD:  next_basePeriod = pwdata[15:0];
                pcc_pkg::IDX_CMP_CTL: next_compareControl = pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // time-base counter
    always_comb begin
        next_baseCounter = baseCounter;
        next_countUp     = countUp;
        if (syncLoad) begin
            next_baseCounter = phaseValue;  // RULE14
            if (tbMode == pcc_pkg::MODE_UPDOWN) begin
                next_countUp = postSyncDirection;
            end
        end else begin
            case (tbMode)  // RULE15
                pcc_pkg::MODE_UP: begin
                    next_countUp     = 1'b1;
                    next_baseCounter = (baseCounter >= basePeriod) ?
                        16'h0000 : baseCounter + 16'h0001;
                end
                pcc_pkg::MODE_DOWN: begin
                    next_countUp     = 1'b0;
                    next_baseCounter = (baseCounter == 16'h0000) ?
                        basePeriod : baseCounter - 16'h0001;
                end
                pcc_pkg::MODE_UPDOWN: begin  // RULE13
                    if (countUp && baseCounter >= basePeriod) begin  // RULE3
                        next_countUp     = 1'b0;
                        next_baseCounter = baseCounter - 16'h0001;
                    end else if (!countUp && baseCounter == 16'h0000) begin
                        next_countUp     = 1'b1;
                        next_baseCounter = 16'h0001;
                    end else if (countUp) begin
                        next_baseCounter = baseCounter + 16'h0001;  // RULE16
                    end else begin
                        next_baseCounter = baseCounter - 16'h0001;
                    end
                end
                default: begin
                end
            endcase
        end
        next_counterZero   = (baseCounter == 16'h0000);
        next_counterPeriod = (baseCounter == basePeriod);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready            <= 1'b0;
            prdata            <= 32'h0000_0000;
            pslverr           <= 1'b0;
            tbMode            <= pcc_pkg::TB_MODE_RST;
            phaseLoadEnable   <= 1'b0;
            postSyncDirection <= 1'b0;
            phaseValue        <= pcc_pkg::PHASE_RST;
            basePeriod        <= pcc_pkg::PERIOD_RST;
            compareControl    <= pcc_pkg::CMP_CTL_RST;  // RULE7
            baseCounter       <= 16'h0000;
            countUp           <= 1'b1;
            counterZero       <= 1'b0;
            counterPeriod     <= 1'b0;
            syncMeta          <= 1'b0;
            syncSeen          <= 1'b0;
            syncLast          <= 1'b0;
        end else begin
            pready            <= next_pready;
            prdata            <= next_prdata;
            pslverr           <= next_pslverr;
            tbMode            <= next_tbMode;
            phaseLoadEnable   <= next_phaseLoadEnable;
            postSyncDirection <= next_postSyncDirection;
            phaseValue        <= next_phaseValue;
            basePeriod        <= next_basePeriod;
            compareControl    <= next_compareControl;
            baseCounter       <= next_baseCounter;
            countUp           <= next_countUp;
            counterZero       <= next_counterZero;
            counterPeriod     <= next_counterPeriod;
            syncMeta          <= syncInput;
            syncSeen          <= syncMeta;
            syncLast          <= syncSeen;
        end
    end

    // per-channel shadow, active copy and equality event
    for (genvar ch = 0; ch < 2; ch++) begin : g_channel
        localparam logic [5:0] CH_IDX =
            (ch == 0) ? pcc_pkg::IDX_CMP_A : pcc_pkg::IDX_CMP_B;
        logic        shadowOff;
        logic [1:0]  loadSel;
        logic        loadHit;
        logic        writeHit;
        logic [15:0] next_active;
        logic [15:0] next_shadow;
        logic        next_event;

        assign shadowOff = compareControl[pcc_pkg::CMP_SHDW_LSB + 2*ch];
        assign loadSel   = compareControl[pcc_pkg::CMP_LOAD_LSB + 2*ch +: 2];
        assign readCompare[ch] = shadowOff ? activeValue[ch]
                                           : shadowValue[ch];  // RULE10

        always_comb begin
            writeHit    = wrEn && (regIndex == CH_IDX);
            loadHit     = 1'b0;
            next_active = activeValue[ch];
            next_shadow = shadowValue[ch];
            case (loadSel)  // RULE8
                pcc_pkg::LOAD_ZERO:   loadHit = (baseCounter == 16'h0000);
                pcc_pkg::LOAD_PERIOD: loadHit = (baseCounter == basePeriod);
                pcc_pkg::LOAD_BOTH: begin
                    loadHit = (baseCounter == 16'h0000) ||
                              (baseCounter == basePeriod);
                end
                default:              loadHit = 1'b0;
            endcase
            if (writeHit && shadowOff) begin
                next_active = pwdata[15:0];  // RULE10
            end else if (!shadowOff && loadHit) begin
                next_active = shadowValue[ch];  // RULE6
            end
            if (writeHit && !shadowOff) begin
                next_shadow = pwdata[15:0];  // RULE5
            end
            // frozen counter gives no repeated events
            next_event = (baseCounter == activeValue[ch]) &&  // RULE9
                         (tbMode != pcc_pkg::MODE_FROZEN);  // RULE1
        end

        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                activeValue[ch] <= pcc_pkg::CMP_RST;
                shadowValue[ch] <= pcc_pkg::CMP_RST;
                cmpEvent[ch]    <= 1'b0;
            end else begin
                activeValue[ch] <= next_active;
                shadowValue[ch] <= next_shadow;
                cmpEvent[ch]    <= next_event;  // RULE2
            end
        end
    end

    default clocking dc @(posedge clock); endclocking
    default disable iff (reset);
    property p_event_a;
        (baseCounter == activeValue[0] && tbMode != pcc_pkg::MODE_FROZEN)
            |=> eventA;
    endproperty
    a_event_a: assert property (p_event_a)  // RULE1
        else $error("event a missing on match");
    property p_event_b_active;
        (baseCounter != activeValue[1]) |=> !eventB;
    endproperty
    a_event_b_active: assert property (p_event_b_active)  // RULE9
        else $error("event b without active match");
    property p_frozen;
        (tbMode == pcc_pkg::MODE_FROZEN && !syncLoad)
            |=> $stable(baseCounter) ##0 !eventA;
    endproperty
    a_frozen: assert property (p_frozen)  // RULE15
        else $error("frozen counter moved or fired");
    property p_phase;
        syncLoad |=> (baseCounter == $past(phaseValue));
    endproperty
    a_phase: assert property (p_phase)  // RULE14
        else $error("phase value not loaded");
    property p_load_zero;
        (!compareControl[pcc_pkg::CMP_SHDW_LSB] && baseCounter == 16'h0000
         && compareControl[pcc_pkg::CMP_LOAD_LSB +: 2] == pcc_pkg::LOAD_ZERO)
            |=> activeValue[0] == $past(shadowValue[0]);
    endproperty
    a_load_zero: assert property (p_load_zero)  // RULE8
        else $error("shadow a not loaded at zero");
    property p_immediate;
        (wrEn && regIndex == pcc_pkg::IDX_CMP_B && g_channel[1].shadowOff)
            |=> activeValue[1] == $past(pwdata[15:0]);
    endproperty
    a_immediate: assert property (p_immediate)  // RULE10
        else $error("immediate write missed active b");
    property p_frac;
        (psel && penable && pready && !pwrite
         && paddr == {pcc_pkg::IDX_CMP_A_FRAC, 2'h0}) |-> prdata == 32'h0;
    endproperty
    a_frac: assert property (p_frac)  // RULE12
        else $error("reserved location read nonzero");
    property p_turn;
        (tbMode == pcc_pkg::MODE_UPDOWN && countUp && !syncLoad
         && baseCounter == basePeriod && basePeriod != 16'h0000)
            |=> !countUp ##0 baseCounter == $past(basePeriod) - 16'h0001;
    endproperty
    a_turn: assert property (p_turn)  // RULE3
        else $error("up-down turn at period wrong");
    property p_ready;
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb answer not one cycle");
    c_event_a: cover property (eventA ##1 !eventA);
    c_sync:    cover property (syncLoad);
    c_load:    cover property (counterPeriod && !g_channel[1].shadowOff);
    c_updown:  cover property (tbMode == pcc_pkg::MODE_UPDOWN && eventB);
endmodule : pcc_compare_unit

/* tb/pcc_far_side.sv */
/*
 * pcc_far_side: action-qualifier stand-in that tallies compare events and
 * issues sync pulses. Assumes it shares the time-base clock with the unit.
 */
`timescale 1ns/1ps
module pcc_far_side (
    input  wire logic        clock,     // time-base clock
    input  wire logic        reset,     // async, active high
    input  wire logic        eventA,    // compare a event
    input  wire logic        eventB,    // compare b event
    input  wire logic        fireSync,  // request one sync pulse
    output logic             syncInput, // sync pulse to the unit
    output logic      [15:0] countA,    // events seen on a
    output logic      [15:0] countB     // events seen on b
);
    logic [15:0] next_countA;
    logic [15:0] next_countB;
    logic        next_syncInput;

    always_comb begin
        next_countA    = countA + {15'h0000, eventA};
        next_countB    = countB + {15'h0000, eventB};
        // one-cycle pulse, always followed by a low sample
        next_syncInput = fireSync & ~syncInput;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            countA    <= 16'h0000;
            countB    <= 16'h0000;
            syncInput <= 1'b0;
        end else begin
            countA    <= next_countA;
            countB    <= next_countB;
            syncInput <= next_syncInput;
        end
    end
endmodule : pcc_far_side

/* tb/tb_pwm_counter_compare_unit.sv */
/*
 * tb_pwm_counter_compare_unit: self-checking bench for the compare unit.
 * Assumes pcc_pkg and the far-side model are compiled first.
 */
`timescale 1ns/1ps
module tb_pwm_counter_compare_unit;
    localparam logic [15:0] PER = 16'h0009;
    logic        clock;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        syncInput;
    logic        eventA;
    logic        eventB;
    logic [15:0] baseCounter;
    logic        counterZero;
    logic        counterPeriod;
    logic        countUp;
    logic [15:0] lastCount;
    logic        armed = 1'b0;
    logic        dirCheck = 1'b1;
    logic        fireSync;
    logic [15:0] countA;
    logic [15:0] countB;
    logic [33:0] notes[$];
    logic [33:0] note;
    int          failures;
    int          num_checks;
    logic [1:0]  modes[3] = '{pcc_pkg::MODE_UP, pcc_pkg::MODE_DOWN,
                              pcc_pkg::MODE_UPDOWN};
    logic [1:0]  loads[3] = '{pcc_pkg::LOAD_ZERO, pcc_pkg::LOAD_PERIOD,
                              pcc_pkg::LOAD_BOTH};
    logic [15:0] aVal;
    int          len;

    pcc_compare_unit pcc_compare_unit_inst (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .syncInput(syncInput),
        .eventA(eventA), .eventB(eventB), .counterZero(counterZero),
        .counterPeriod(counterPeriod), .countUp(countUp),
        .baseCounter(baseCounter));

    pcc_far_side pcc_far_side_inst (
        .clock(clock), .reset(reset), .eventA(eventA), .eventB(eventB),
        .fireSync(fireSync), .syncInput(syncInput), .countA(countA),
        .countB(countB));

    always #2 clock = ~clock;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // expected answer is queued at setup, compared when pready comes
    task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
             input logic [31:0] ed, input logic ee);
        @(posedge clock);
        notes.push_back({~wr, ee, ed});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 32'h0, 1'b0);
    endtask : wr

    task rd(input logic [5:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0, e, 1'b0);
    endtask : rd

    // event tally over a window of whole counter cycles
    task win(input int n, input logic [15:0] ea, input logic [15:0] eb);
        logic [15:0] sa;
        logic [15:0] sb;
        sa = countA;
        sb = countB;
        repeat (n) @(posedge clock);
        chk(32'(countA - sa), 32'(ea));
        chk(32'(countB - sb), 32'(eb));
    endtask : win

    task finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            if (note[33])
                chk(prdata, note[31:0]);
            chk({31'h0, pslverr}, {31'h0, note[32]});
        end
    end

    // zero/period flags trail the counter by one cycle; direction matches the step just taken
    always @(posedge clock) begin
        if (armed) begin
            chk({31'h0, counterZero}, {31'h0, lastCount == 16'h0});
            chk({31'h0, counterPeriod}, {31'h0, lastCount == PER});
            if (dirCheck && baseCounter == lastCount + 16'h1)
                chk({31'h0, countUp}, 32'h1);
            if (dirCheck && baseCounter == lastCount - 16'h1)
                chk({31'h0, countUp}, 32'h0);
        end
        armed     <= !reset;
        lastCount <= baseCounter;
    end

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        finish_test();
    end

    initial begin
        clock = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; fireSync = 1'b0;
        failures = 0;
        num_checks = 0;
        void'($urandom(82));
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rd(pcc_pkg::IDX_CMP_CTL, 32'h0);
        rd(pcc_pkg::IDX_CMP_A, 32'h0);
        rd(pcc_pkg::IDX_CMP_B, 32'h0);
        wr(pcc_pkg::IDX_CMP_A_FRAC, 32'h1234);
        rd(pcc_pkg::IDX_CMP_A_FRAC, 32'h0);
        apb(1'b0, 6'h02, 32'h0, 32'h0, 1'b1);
        $display("test reset values done");
        wr(pcc_pkg::IDX_PERIOD, {16'h0, PER});
        for (int i = 0; i < 3; i++) begin
            len  = (modes[i] == pcc_pkg::MODE_UPDOWN) ? 2 * PER : PER + 1;
            aVal = 16'h1 + 16'($urandom % (PER - 1));
            wr(pcc_pkg::IDX_CMP_CTL, {28'h0, loads[i], loads[i]});
            wr(pcc_pkg::IDX_CMP_A, {16'h0, aVal});
            wr(pcc_pkg::IDX_CMP_B, 32'h0);
            rd(pcc_pkg::IDX_CMP_A, {16'h0, aVal});
            wr(pcc_pkg::IDX_TB_CTL, {30'h0, modes[i]});
            repeat (2 * len) @(posedge clock);
            win(2 * len, (len == 2 * PER) ? 16'h4 : 16'h2, 16'h2);
            wr(pcc_pkg::IDX_CMP_A, {16'h0, PER + 16'h1});
            repeat (2 * len) @(posedge clock);
            win(len, 16'h0, 16'h1);
            $display("test mode %0d done", i);
        end
        dirCheck <= 1'b0;
        wr(pcc_pkg::IDX_TB_CTL, {29'h0, 1'b1, pcc_pkg::MODE_FROZEN});
        wr(pcc_pkg::IDX_PHASE, 32'h5);
        @(posedge clock);
        fireSync <= 1'b1;
        @(posedge clock);
        fireSync <= 1'b0;
        repeat (12) @(posedge clock);
        chk(32'(baseCounter), 32'h5);
        $display("test sync done");
        wr(pcc_pkg::IDX_CMP_A, 32'h7);
        rd(pcc_pkg::IDX_CMP_A, 32'h7);
        wr(pcc_pkg::IDX_CMP_CTL, 32'h10);
        rd(pcc_pkg::IDX_CMP_A, {16'h0, PER + 16'h1});
        wr(pcc_pkg::IDX_CMP_A, 32'h3);
        rd(pcc_pkg::IDX_CMP_A, 32'h3);
        wr(pcc_pkg::IDX_CMP_CTL, 32'h40);
        rd(pcc_pkg::IDX_CMP_A, 32'h7);
        rd(pcc_pkg::IDX_CMP_B, 32'h0);
        wr(pcc_pkg::IDX_CMP_B, 32'h4);
        rd(pcc_pkg::IDX_CMP_B, 32'h4);
        chk(32'(baseCounter), 32'h5);
        $display("test shadow select done");
        finish_test();
    end
endmodule : tb_pwm_counter_compare_unit
